// File: include/ncr_pkg.sv
// Purpose: Constants for the nibble core register set and operand address generator.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
package ncr_pkg;
	localparam logic [7:0] OFF_DATA = 8'h00;
	localparam logic [7:0] OFF_FIRST_PTR = 8'h04;
	localparam logic [7:0] OFF_SECOND_PTR = 8'h08;
	localparam logic [7:0] OFF_FLAGS = 8'h0C;
	localparam logic [7:0] OFF_PREFIX = 8'h10;
	localparam logic [7:0] OFF_MAIN_SP = 8'h14;
	localparam logic [7:0] OFF_NIBBLE_SP = 8'h18;
	localparam logic [7:0] OFF_PC = 8'h1C;
	localparam logic [7:0] OFF_ADDR_REQ = 8'h20;
	localparam logic [7:0] OFF_ADDR_OUT = 8'h24;
	localparam logic [7:0] OFF_EVENT = 8'h28;
	localparam logic [15:0] RESET_START_PC = 16'h0110;
	localparam logic [15:0] NMI_VECTOR_PC = 16'h0100;
	localparam logic [15:0] IO_REGION_BASE = 16'hFF00;
	localparam logic [9:0] LOW6_UPPER = 10'h000;
	localparam logic [9:0] HIGH6_UPPER = 10'h3FF;
	localparam logic [7:0] LOW8_UPPER = 8'h00;
	localparam logic [7:0] HIGH8_UPPER = 8'hFF;
	localparam logic [15:0] MAIN_SP_STEP = 16'h0004;
	localparam logic [15:0] NIBBLE_SP_STEP = 16'h0001;
	localparam int MAIN_SP_LO = 2;
	localparam int MAIN_SP_HI = 9;
	// Addressing modes in the address request register, bits 2:0.
	localparam logic [2:0] MODE_LOW6 = 3'h0;
	localparam logic [2:0] MODE_HIGH6 = 3'h1;
	localparam logic [2:0] MODE_LOW8 = 3'h2;
	localparam logic [2:0] MODE_HIGH8 = 3'h3;
	localparam logic [2:0] MODE_FIRST_PTR = 3'h4;
	localparam logic [2:0] MODE_SECOND_PTR = 3'h5;
	localparam logic [2:0] MODE_MAIN_SP = 3'h6;
	localparam logic [2:0] MODE_NIBBLE_SP = 3'h7;
	// Event register bits: written as one to act.
	localparam int EV_NMI = 0;
	localparam int EV_PUSH_MAIN = 1;
	localparam int EV_POP_MAIN = 2;
	localparam int EV_PUSH_NIBBLE = 3;
	localparam int EV_POP_NIBBLE = 4;
	localparam int EV_FETCH = 5;
	localparam int FLAG_E = 3;
endpackage : ncr_pkg

// File: verilog/ncr_core.sv
// Purpose: Register set and operand address generation of a 4-bit core.
// Assumes: APB master holds each request until pready; pclk 100 MHz.
// Notes: Zero-wait-state slave, pready high in every access phase.
`timescale 1ns/1ps
module ncr_core (
	input wire logic pclk, // Bus clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // Slave select.
	input wire logic penable, // Access phase.
	input wire logic pwrite, // Write when high.
	input wire logic [7:0] paddr, // Byte address.
	input wire logic [31:0] pwdata, // Write data.
	output logic [31:0] prdata, // Read data.
	output logic pready, // Transfer done.
	output logic pslverr, // Unmapped address.
	output logic [15:0] data_addr, // Data memory address.
	output logic data_is_io, // Address falls in the I/O region.
	output logic [4:0] stack_width, // Bits moved by the current stack access.
	output logic [15:0] prog_addr // Program memory fetch address.
);
	logic [3:0] reg_a_reg;
	logic [3:0] reg_b_reg;
	logic [7:0] first_pointer_high_reg;
	logic [7:0] first_pointer_low_reg;
	logic [7:0] second_pointer_high_reg;
	logic [7:0] second_pointer_low_reg;
	logic [3:0] flags_reg;
	logic [7:0] prefix_operand_reg;
	logic [15:0] main_stack_pointer_reg;
	logic [15:0] nibble_stack_pointer_reg;
	logic [15:0] pc_reg;
	logic [10:0] addr_req_reg;
	logic [15:0] data_addr_reg;
	logic data_is_io_reg;
	logic [4:0] stack_width_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic pready_reg;
	logic req_prefix_reg;

	wire [15:0] first_pointer = {first_pointer_high_reg, first_pointer_low_reg};
	wire [15:0] second_pointer = {second_pointer_high_reg, second_pointer_low_reg};
	wire [7:0] data_pair = {reg_b_reg, reg_a_reg};
	wire setup = psel && !penable;
	wire wr = setup && pwrite;
	wire rd = setup && !pwrite;
	wire hit_data = paddr == ncr_pkg::OFF_DATA;
	wire hit_first = paddr == ncr_pkg::OFF_FIRST_PTR;
	wire hit_second = paddr == ncr_pkg::OFF_SECOND_PTR;
	wire hit_flags = paddr == ncr_pkg::OFF_FLAGS;
	wire hit_prefix = paddr == ncr_pkg::OFF_PREFIX;
	wire hit_msp = paddr == ncr_pkg::OFF_MAIN_SP;
	wire hit_nsp = paddr == ncr_pkg::OFF_NIBBLE_SP;
	wire hit_pc = paddr == ncr_pkg::OFF_PC;
	wire hit_req = paddr == ncr_pkg::OFF_ADDR_REQ;
	wire hit_out = paddr == ncr_pkg::OFF_ADDR_OUT;
	wire hit_ev = paddr == ncr_pkg::OFF_EVENT;
	wire mapped = hit_data || hit_first || hit_second || hit_flags || hit_prefix || hit_msp
		|| hit_nsp || hit_pc || hit_req || hit_out || hit_ev;
	wire ev_wr = wr && hit_ev;
	wire ev_nmi = ev_wr && pwdata[ncr_pkg::EV_NMI];
	wire ev_fetch = ev_wr && pwdata[ncr_pkg::EV_FETCH];
	wire ev_push_m = ev_wr && pwdata[ncr_pkg::EV_PUSH_MAIN];
	wire ev_pop_m = ev_wr && pwdata[ncr_pkg::EV_POP_MAIN];
	wire ev_push_n = ev_wr && pwdata[ncr_pkg::EV_PUSH_NIBBLE];
	wire ev_pop_n = ev_wr && pwdata[ncr_pkg::EV_POP_NIBBLE];
	wire [2:0] req_mode = addr_req_reg[2:0];
	wire [7:0] req_oper = addr_req_reg[10:3];
	// A prefix is taken as loaded while the extension flag stands.
	wire prefix_live = flags_reg[ncr_pkg::FLAG_E];

	// Short forms never carry into the upper bits; the page is a fixed pattern.
	function automatic logic [15:0] page_addr(input logic [2:0] mode, input logic [7:0] op);
		case (mode)
			ncr_pkg::MODE_LOW6: page_addr = {ncr_pkg::LOW6_UPPER, op[5:0]};
			ncr_pkg::MODE_HIGH6: page_addr = {ncr_pkg::HIGH6_UPPER, op[5:0]};
			ncr_pkg::MODE_LOW8: page_addr = {ncr_pkg::LOW8_UPPER, op};
			default: page_addr = {ncr_pkg::HIGH8_UPPER, op};
		endcase
	endfunction : page_addr

	logic [15:0] addr_next;
	logic [4:0] width_next;
	always_comb begin
		width_next = '0;
		case (req_mode)
			ncr_pkg::MODE_FIRST_PTR: begin
				addr_next = req_prefix_reg ? page_addr(ncr_pkg::MODE_LOW8, prefix_operand_reg)
					: first_pointer;
			end
			ncr_pkg::MODE_SECOND_PTR: begin
				addr_next = second_pointer;
			end
			ncr_pkg::MODE_MAIN_SP: begin
				addr_next = main_stack_pointer_reg;
				width_next = 5'h10;
			end
			ncr_pkg::MODE_NIBBLE_SP: begin
				addr_next = nibble_stack_pointer_reg;
				width_next = 5'h04;
			end
			default: begin
				addr_next = page_addr(req_mode, req_oper);
			end
		endcase
	end

	logic [31:0] rdata_next;
	always_comb begin
		rdata_next = '0;
		if (hit_data) rdata_next = {24'h00_0000, data_pair};
		if (hit_first) rdata_next = {16'h0000, first_pointer};
		if (hit_second) rdata_next = {16'h0000, second_pointer};
		if (hit_flags) rdata_next = {28'h000_0000, flags_reg};
		if (hit_prefix) rdata_next = {24'h00_0000, prefix_operand_reg};
		if (hit_msp) rdata_next = {16'h0000, main_stack_pointer_reg};
		if (hit_nsp) rdata_next = {16'h0000, nibble_stack_pointer_reg};
		if (hit_pc) rdata_next = {16'h0000, pc_reg};
		if (hit_req) rdata_next = {21'h00_0000, addr_req_reg};
		if (hit_out) rdata_next = {15'h0000, data_is_io_reg, data_addr_reg};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_a_reg <= '0;
			reg_b_reg <= '0;
		end else if (wr && hit_data) begin
			reg_a_reg <= pwdata[3:0];
			reg_b_reg <= pwdata[7:4];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_pointer_high_reg <= '0;
			first_pointer_low_reg <= '0;
			second_pointer_high_reg <= '0;
			second_pointer_low_reg <= '0;
		end else begin
			if (wr && hit_first) first_pointer_low_reg <= pwdata[7:0];
			if (wr && hit_first) first_pointer_high_reg <= pwdata[15:8];
			if (wr && hit_second) second_pointer_low_reg <= pwdata[7:0];
			if (wr && hit_second) second_pointer_high_reg <= pwdata[15:8];
		end
	end

	// A write to the address request register consumes the prefix, matching one-shot use.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= '0;
			prefix_operand_reg <= '0;
		end else if (wr && hit_prefix) begin
			prefix_operand_reg <= pwdata[7:0];
			flags_reg[ncr_pkg::FLAG_E] <= 1'b1;
		end else if (wr && hit_flags) begin
			flags_reg <= pwdata[3:0];
		end else if (wr && hit_req) begin
			flags_reg[ncr_pkg::FLAG_E] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_stack_pointer_reg <= '0;
		end else if (wr && hit_msp) begin
			main_stack_pointer_reg <= {6'h00, pwdata[ncr_pkg::MAIN_SP_HI:ncr_pkg::MAIN_SP_LO],
				2'h0};
		end else if (ev_push_m) begin
			main_stack_pointer_reg <= main_stack_pointer_reg - ncr_pkg::MAIN_SP_STEP;
		end else if (ev_pop_m) begin
			main_stack_pointer_reg <= main_stack_pointer_reg + ncr_pkg::MAIN_SP_STEP;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nibble_stack_pointer_reg <= '0;
		end else if (wr && hit_nsp) begin
			nibble_stack_pointer_reg <= {8'h00, pwdata[7:0]};
		end else if (ev_push_n) begin
			nibble_stack_pointer_reg <= nibble_stack_pointer_reg - ncr_pkg::NIBBLE_SP_STEP;
		end else if (ev_pop_n) begin
			nibble_stack_pointer_reg <= nibble_stack_pointer_reg + ncr_pkg::NIBBLE_SP_STEP;
		end
	end

	// The interrupt outranks a direct write and a fetch step in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg <= ncr_pkg::RESET_START_PC;
		end else if (ev_nmi) begin
			pc_reg <= ncr_pkg::NMI_VECTOR_PC;
		end else if (wr && hit_pc) begin
			pc_reg <= pwdata[15:0];
		end else if (ev_fetch) begin
			pc_reg <= pc_reg + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_req_reg <= '0;
		end else if (wr && hit_req) begin
			addr_req_reg <= pwdata[10:0];
		end
	end

	// The request write clears the extension flag, so the flag's state travels with the request.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_prefix_reg <= 1'b0;
		end else if (wr && hit_req) begin
			req_prefix_reg <= prefix_live;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_addr_reg <= '0;
			data_is_io_reg <= 1'b0;
			stack_width_reg <= '0;
		end else begin
			data_addr_reg <= addr_next;
			data_is_io_reg <= addr_next >= ncr_pkg::IO_REGION_BASE;
			stack_width_reg <= width_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= setup;
			pslverr_reg <= setup && !mapped;
			if (rd) prdata_reg <= rdata_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign data_addr = data_addr_reg;
	assign data_is_io = data_is_io_reg;
	assign stack_width = stack_width_reg;
	assign prog_addr = pc_reg;

	property p_reset_pc;
		@(posedge pclk) $rose(presetn) |-> prog_addr == ncr_pkg::RESET_START_PC;
	endproperty
	a_reset_pc: assert property (p_reset_pc) else $error("Start address wrong.");

	property p_nmi;
		@(posedge pclk) disable iff (!presetn) ev_nmi |=> prog_addr == ncr_pkg::NMI_VECTOR_PC;
	endproperty
	a_nmi: assert property (p_nmi) else $error("Interrupt vector wrong.");

	property p_msp_load;
		@(posedge pclk) disable iff (!presetn) wr && hit_msp |=>
			main_stack_pointer_reg == {6'h00, $past(pwdata[9:2]), 2'h0};
	endproperty
	a_msp_load: assert property (p_msp_load) else $error("Main stack load wrong.");

	property p_nsp_load;
		@(posedge pclk) disable iff (!presetn) wr && hit_nsp |=>
			nibble_stack_pointer_reg == {8'h00, $past(pwdata[7:0])};
	endproperty
	a_nsp_load: assert property (p_nsp_load) else $error("Nibble stack load wrong.");

	property p_io;
		@(posedge pclk) disable iff (!presetn) data_is_io == (data_addr[15:8] == 8'hFF);
	endproperty
	a_io: assert property (p_io) else $error("I/O region flag wrong.");

	property p_high6;
		@(posedge pclk) disable iff (!presetn) req_mode == ncr_pkg::MODE_HIGH6 |=>
			data_addr[15:6] == 10'h3FF;
	endproperty
	a_high6: assert property (p_high6) else $error("High six-bit page wrong.");

	property p_low8;
		@(posedge pclk) disable iff (!presetn) req_mode == ncr_pkg::MODE_LOW8 |=>
			data_addr == {8'h00, $past(req_oper)};
	endproperty
	a_low8: assert property (p_low8) else $error("Low eight-bit page wrong.");

	property p_prefix;
		@(posedge pclk) disable iff (!presetn)
			req_mode == ncr_pkg::MODE_FIRST_PTR && req_prefix_reg |=>
			data_addr == {8'h00, $past(prefix_operand_reg)};
	endproperty
	a_prefix: assert property (p_prefix) else $error("Prefixed pointer wrong.");

	property p_low6;
		@(posedge pclk) disable iff (!presetn) req_mode == ncr_pkg::MODE_LOW6 |=>
			data_addr == {ncr_pkg::LOW6_UPPER, $past(req_oper[5:0])};
	endproperty
	a_low6: assert property (p_low6) else $error("Low six-bit page wrong.");

	property p_high8;
		@(posedge pclk) disable iff (!presetn) req_mode == ncr_pkg::MODE_HIGH8 |=>
			data_addr == {ncr_pkg::HIGH8_UPPER, $past(req_oper)};
	endproperty
	a_high8: assert property (p_high8) else $error("High eight-bit page wrong.");

	property p_main_width;
		@(posedge pclk) disable iff (!presetn) req_mode == ncr_pkg::MODE_MAIN_SP |=>
			stack_width == 5'h10;
	endproperty
	a_main_width: assert property (p_main_width) else $error("Main stack width wrong.");

	property p_pair;
		@(posedge pclk) disable iff (!presetn) wr && hit_data |=>
			reg_b_reg == $past(pwdata[7:4]) && reg_a_reg == $past(pwdata[3:0]);
	endproperty
	a_pair: assert property (p_pair) else $error("Data pair load wrong.");

	property p_fetch;
		@(posedge pclk) disable iff (!presetn) ev_fetch && !ev_nmi |=>
			prog_addr == $past(prog_addr) + 16'h0001;
	endproperty
	a_fetch: assert property (p_fetch) else $error("Fetch step wrong.");

	property p_ready;
		@(posedge pclk) disable iff (!presetn) setup |=> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready) else $error("Bus answer timing wrong.");
endmodule : ncr_core

// File: testbench/ncr_mem_model.sv
// Purpose: Behavioural program and data memory seen by the nibble core.
// Assumes: Addresses come straight from the core outputs, one clock.
// Notes: Contents start unknown, so a read of an unwritten cell shows up at once.
`timescale 1ns/1ps
module ncr_mem_model (
	input wire logic pclk, // Core clock.
	input wire logic [15:0] data_addr, // Data memory address.
	input wire logic data_is_io, // Address lies in the I/O region.
	input wire logic [15:0] prog_addr, // Program fetch address.
	output logic [3:0] mem_nibble, // Data nibble at data_addr.
	output logic [15:0] code_word // Instruction word at prog_addr.
);
	logic [3:0] dmem [1024];
	logic [3:0] iomem [256];
	logic [15:0] pmem [1024];
	// I/O cells are a separate store, so they never alias general data.
	always_ff @(posedge pclk) begin
		mem_nibble <= data_is_io ? iomem[data_addr[7:0]] : dmem[data_addr[9:0]];
		code_word <= pmem[prog_addr[9:0]];
	end
endmodule : ncr_mem_model

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the nibble core register set.
// Assumes: Zero-wait APB slave, but the bus tasks still wait for pready.
// Notes: The verdict is printed only by test_done.
`timescale 1ns/1ps
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, data_is_io, qerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] data_addr, prog_addr;
	logic [4:0] stack_width;
	int bad_count, checks;
	ncr_core u_ncr_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .data_addr(data_addr), .data_is_io(data_is_io),
		.stack_width(stack_width), .prog_addr(prog_addr));
	ncr_mem_model u_ncr_mem_model (.pclk(pclk), .data_addr(data_addr),
		.data_is_io(data_is_io), .prog_addr(prog_addr), .mem_nibble(), .code_word());
	always #5 pclk = ~pclk;
	task automatic test_done();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// Psel stays high at the end; each call drives psel high again for its own setup phase.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		qerr = pslverr;
		if (n >= 50) begin
			bad_count++;
			test_done();
		end
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask : rd
	task automatic req(input logic [2:0] m, input logic [7:0] op, input logic [16:0] e,
		input logic [4:0] sw);
		wr(ncr_pkg::OFF_ADDR_REQ, {21'h00_0000, op, m});
		rd(ncr_pkg::OFF_ADDR_OUT, {15'h0000, e});
		chk({27'h000_0000, stack_width}, {27'h000_0000, sw});
		chk({15'h0000, data_is_io, data_addr}, {15'h0000, e});
	endtask : req
	initial begin
		repeat (3000) @(posedge pclk);
		bad_count++;
		test_done();
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		chk({16'h0000, prog_addr}, 32'h0000_0110);
		wr(ncr_pkg::OFF_DATA, 32'hFFFF_FFAB);
		rd(ncr_pkg::OFF_DATA, 32'h0000_00AB);
		wr(ncr_pkg::OFF_FIRST_PTR, 32'hFFFF_1234);
		rd(ncr_pkg::OFF_FIRST_PTR, 32'h0000_1234);
		wr(ncr_pkg::OFF_SECOND_PTR, 32'h0000_FF12);
		rd(ncr_pkg::OFF_SECOND_PTR, 32'h0000_FF12);
		wr(ncr_pkg::OFF_MAIN_SP, 32'hFFFF_FFFF);
		rd(ncr_pkg::OFF_MAIN_SP, 32'h0000_03FC);
		wr(ncr_pkg::OFF_NIBBLE_SP, 32'hFFFF_FFFF);
		rd(ncr_pkg::OFF_NIBBLE_SP, 32'h0000_00FF);
		rd(8'h30, 32'h0000_0000);
		chk({31'h0, qerr}, 32'h0000_0001);
		$display("test registers done");
		req(ncr_pkg::MODE_LOW6, 8'hFF, 17'h0_003F, 5'd0);
		req(ncr_pkg::MODE_HIGH6, 8'h00, 17'h1_FFC0, 5'd0);
		req(ncr_pkg::MODE_HIGH6, 8'hFF, 17'h1_FFFF, 5'd0);
		req(ncr_pkg::MODE_LOW8, 8'hFF, 17'h0_00FF, 5'd0);
		req(ncr_pkg::MODE_HIGH8, 8'h00, 17'h1_FF00, 5'd0);
		req(ncr_pkg::MODE_FIRST_PTR, 8'h00, 17'h0_1234, 5'd0);
		req(ncr_pkg::MODE_SECOND_PTR, 8'h00, 17'h1_FF12, 5'd0);
		req(ncr_pkg::MODE_MAIN_SP, 8'h00, 17'h0_03FC, 5'd16);
		req(ncr_pkg::MODE_NIBBLE_SP, 8'h00, 17'h0_00FF, 5'd4);
		$display("test addressing done");
		wr(ncr_pkg::OFF_EVENT, 32'h0000_0002);
		rd(ncr_pkg::OFF_MAIN_SP, 32'h0000_03F8);
		wr(ncr_pkg::OFF_EVENT, 32'h0000_0010);
		rd(ncr_pkg::OFF_NIBBLE_SP, 32'h0000_0100);
		wr(ncr_pkg::OFF_FLAGS, 32'h0000_0005);
		rd(ncr_pkg::OFF_FLAGS, 32'h0000_0005);
		wr(ncr_pkg::OFF_PREFIX, 32'h0000_005A);
		rd(ncr_pkg::OFF_PREFIX, 32'h0000_005A);
		rd(ncr_pkg::OFF_FLAGS, 32'h0000_000D);
		req(ncr_pkg::MODE_FIRST_PTR, 8'h00, 17'h0_005A, 5'd0);
		rd(ncr_pkg::OFF_FLAGS, 32'h0000_0005);
		$display("test stack and prefix done");
		wr(ncr_pkg::OFF_PC, 32'h0000_BEEF);
		rd(ncr_pkg::OFF_PC, 32'h0000_BEEF);
		wr(ncr_pkg::OFF_EVENT, 32'h0000_0020);
		chk({16'h0000, prog_addr}, 32'h0000_BEF0);
		wr(ncr_pkg::OFF_EVENT, 32'h0000_0001);
		chk({16'h0000, prog_addr}, 32'h0000_0100);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		$display("test program counter done");
		test_done();
	end
endmodule : testbench
